// file: verilog/hbfl_pkg.sv
// package: constants for the half bridge fault latch
package hbfl_pkg;
  localparam int NUM_BRIDGES = 3;
  // register offsets (byte address of a 32-bit word, word index = address / 4)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GSTAT = 8'h04;
  localparam logic [7:0] ADDR_OCDIAG = 8'h08;
  localparam logic [7:0] ADDR_OLDIAG = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // global status field positions
  localparam int GS_TPW_BIT = 1;
  localparam int GS_TSD_BIT = 2;
  localparam int GS_OV_BIT = 4;
  localparam int GS_UV_BIT = 5;
  localparam int GS_LE_BIT = 6;
  // control layout: bit 2n high side, bit 2n+1 low side of bridge n
  localparam int CTRL_W = 2 * NUM_BRIDGES;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [7:0] GSTAT_RESET = 8'h00;
  // interrupt status layout
  localparam int IRQ_OC_BIT = 0;
  localparam int IRQ_OL_BIT = 1;
  localparam int IRQ_TPW_BIT = 2;
  localparam int IRQ_TSD_BIT = 3;
  localparam int IRQ_SUP_BIT = 4;
  localparam int IRQ_W = 5;
  // overcurrent filter time in ns, and its count at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int OC_FILTER_TIME_NS = 1000;
  localparam int OC_FILTER_CYCLES =
    (OC_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_CNT_W = 8;
endpackage : hbfl_pkg

// file: verilog/hbfl_filt_if.sv
// interface: overcurrent filter request and expiry between modules
`timescale 1ns/10ps
interface hbfl_filt_if;
  logic [5:0] over_thr;
  logic [5:0] expired;
  modport filter (input over_thr, output expired);
  modport user (output over_thr, input expired);
endinterface : hbfl_filt_if

// file: verilog/hbfl_oc_filter.sv
// module: per-switch overcurrent shutdown filter timers
`timescale 1ns/10ps
module hbfl_oc_filter (
  input wire logic clk_i,
  input wire logic reset_i,
  hbfl_filt_if.filter flt
);
  // =====================================================
  // one counter per switch
  genvar g;
  generate
    for (g = 0; g < hbfl_pkg::CTRL_W; g = g + 1) begin : g_sw
      logic [hbfl_pkg::OC_CNT_W-1:0] cnt_r;
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          cnt_r <= 8'h00;
        end else if (!flt.over_thr[g]) begin
          cnt_r <= 8'h00;
        end else if (cnt_r < 8'(hbfl_pkg::OC_FILTER_CYCLES)) begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
      // expiry only after the full filter time of continuous excess
      assign flt.expired[g] = flt.over_thr[g] &&
        (cnt_r == 8'(hbfl_pkg::OC_FILTER_CYCLES));
    end
  endgenerate
endmodule : hbfl_oc_filter

// file: verilog/hbfl_top.sv
// module: fault latch and output gating for three half bridges
// How it works
// - current above threshold starts filter; act only when filter expires
// - on expiry latch switch off and set its overcurrent bit
// - any filter expiry or open load on a driven switch sets load fault bit 6
// - overcurrent switch stays off while its error bit stays set
// - clearing the error bit restarts switch if still enabled
// - faults never change control bits, only force outputs off
// - open load sets its latched bit, output unchanged
// - open load never alters output; indication stays until cleared
// - thermal prewarning sets status bit 1, no output change
// - thermal shutdown sets bit 2, all outputs off until cleared
// - thermal shutdown turns off every output together
// - undervoltage sets bit 5 and switches all outputs off
// - overvoltage sets bit 4 and switches all outputs off
// - supply fault end reenables outputs; status bit stays until cleared
// - high sides guard shorts to ground, low sides to supply
// - enable low turns outputs off and resets all registers
`timescale 1ns/10ps
module hbfl_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [5:0] overcurrent_threshold_i,
  input wire logic [5:0] openload_i,
  input wire logic thermal_prewarning_i,
  input wire logic thermal_shutdown_i,
  input wire logic supply_undervoltage_i,
  input wire logic supply_overvoltage_i,
  output logic [5:0] switch_on_o,
  output logic error_flag_o,
  output logic irq_o
);
  // =====================================================
  // pin synchronisers
  logic [11:0] pin_s1_r;
  logic [11:0] pin_s2_r;
  logic en_s1_r;
  logic en_s2_r;
  logic [11:0] pin_raw;
  assign pin_raw = {supply_overvoltage_i, supply_undervoltage_i,
                    thermal_shutdown_i, thermal_prewarning_i,
                    openload_i, 2'b00};
  logic [5:0] oc_s1_r;
  logic [5:0] oc_s2_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1_r <= 12'h000;
      pin_s2_r <= 12'h000;
      oc_s1_r <= 6'h00;
      oc_s2_r <= 6'h00;
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      oc_s1_r <= overcurrent_threshold_i;
      oc_s2_r <= oc_s1_r;
      en_s1_r <= enable_i;
      en_s2_r <= en_s1_r;
    end
  end

  logic [5:0] ol_s;
  logic tpw_s;
  logic tsd_s;
  logic uv_s;
  logic ov_s;
  logic sleep;
  assign ol_s = pin_s2_r[7:2];
  assign tpw_s = pin_s2_r[8];
  assign tsd_s = pin_s2_r[9];
  assign uv_s = pin_s2_r[10];
  assign ov_s = pin_s2_r[11];
  // enable low acts as a synchronous reset of all six registers of the map
  assign sleep = !en_s2_r;

  // =====================================================
  // overcurrent filters
  hbfl_filt_if filt ();
  // only a switch that is driven can carry overcurrent; gating by the
  // driven state keeps a latched-off switch from retriggering
  assign filt.over_thr = oc_s2_r & switch_on_o;

  hbfl_oc_filter u_filt (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .flt(filt.filter)
  );

  // =====================================================
  // register write decode
  function automatic logic wr_hit(input logic [7:0] a,
                                  input logic [7:0] reg_a,
                                  input logic w);
    wr_hit = w && (a == reg_a);
  endfunction : wr_hit

  logic wr_ctrl;
  logic wr_gstat;
  logic wr_oc;
  logic wr_ol;
  logic wr_istat;
  logic wr_imask;
  assign wr_ctrl = wr_hit(addr_i, hbfl_pkg::ADDR_CTRL, wr_i);
  assign wr_gstat = wr_hit(addr_i, hbfl_pkg::ADDR_GSTAT, wr_i);
  assign wr_oc = wr_hit(addr_i, hbfl_pkg::ADDR_OCDIAG, wr_i);
  assign wr_ol = wr_hit(addr_i, hbfl_pkg::ADDR_OLDIAG, wr_i);
  assign wr_istat = wr_hit(addr_i, hbfl_pkg::ADDR_IRQ_STAT, wr_i);
  assign wr_imask = wr_hit(addr_i, hbfl_pkg::ADDR_IRQ_MASK, wr_i);

  // =====================================================
  // control register
  logic [5:0] ctrl_r;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_r <= hbfl_pkg::CTRL_RESET;
    end else if (sleep) begin
      ctrl_r <= hbfl_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      // only software writes and enable low change these; faults leave them alone
      ctrl_r <= wdata_i[5:0];
    end
  end

  // =====================================================
  // overcurrent and open load diagnosis, write one to clear
  logic [5:0] oc_diag_r;
  logic [5:0] ol_diag_r;
  logic [5:0] ol_gated;
  // open load is only judged on a switch that is on
  assign ol_gated = ol_s & switch_on_o;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      oc_diag_r <= 6'h00;
    end else if (sleep) begin
      oc_diag_r <= 6'h00;
    end else begin
      // a new expiry wins over a same-cycle clear
      oc_diag_r <= (oc_diag_r & ~(wr_oc ? wdata_i[5:0] : 6'h00))
                   | filt.expired;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ol_diag_r <= 6'h00;
    end else if (sleep) begin
      ol_diag_r <= 6'h00;
    end else begin
      ol_diag_r <= (ol_diag_r & ~(wr_ol ? wdata_i[5:0] : 6'h00))
                   | ol_gated;
    end
  end

  // =====================================================
  // global status register, write one to clear
  logic [7:0] gstat_r;
  logic [7:0] gset;
  logic [7:0] gclr;
  always_comb begin
    gset = 8'h00;
    gset[hbfl_pkg::GS_TPW_BIT] = tpw_s;
    gset[hbfl_pkg::GS_TSD_BIT] = tsd_s;
    gset[hbfl_pkg::GS_OV_BIT] = ov_s;
    gset[hbfl_pkg::GS_UV_BIT] = uv_s;
    gset[hbfl_pkg::GS_LE_BIT] = |filt.expired | |ol_gated;
  end
  assign gclr = wr_gstat ? wdata_i[7:0] : 8'h00;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gstat_r <= hbfl_pkg::GSTAT_RESET;
    end else if (sleep) begin
      gstat_r <= hbfl_pkg::GSTAT_RESET;
    end else begin
      gstat_r <= (gstat_r & ~gclr) | gset;
    end
  end

  // =====================================================
  // output stage gating
  logic all_off;
  logic [5:0] sw_nxt;
  // supply faults use the live level, so outputs return on their own;
  // thermal shutdown uses the latched bit, held until software clears it
  assign all_off = sleep || gstat_r[hbfl_pkg::GS_TSD_BIT] || tsd_s
                   || uv_s || ov_s;
  // recovery follows from the live supply terms above
  assign sw_nxt = all_off ? 6'h00 : (ctrl_r & ~oc_diag_r
                  & ~filt.expired);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      switch_on_o <= 6'h00;
    end else begin
      switch_on_o <= sw_nxt;
    end
  end

  // =====================================================
  // error flag
  logic ef_nxt;
  assign ef_nxt = |oc_diag_r | |ol_diag_r
                  | gstat_r[hbfl_pkg::GS_TPW_BIT]
                  | gstat_r[hbfl_pkg::GS_TSD_BIT]
                  | gstat_r[hbfl_pkg::GS_OV_BIT]
                  | gstat_r[hbfl_pkg::GS_UV_BIT]
                  | gstat_r[hbfl_pkg::GS_LE_BIT];
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      error_flag_o <= 1'b0;
    end else begin
      error_flag_o <= ef_nxt;
    end
  end

  // =====================================================
  // interrupt status and mask
  logic [4:0] istat_r;
  logic [4:0] imask_r;
  logic [4:0] iset;
  assign iset = {uv_s | ov_s, tsd_s, tpw_s, |ol_gated, |filt.expired};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      istat_r <= 5'h00;
    end else if (sleep) begin
      istat_r <= 5'h00;
    end else begin
      istat_r <= (istat_r & ~(wr_istat ? wdata_i[4:0] : 5'h00)) | iset;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      imask_r <= 5'h00;
    end else if (sleep) begin
      imask_r <= 5'h00;
    end else if (wr_imask) begin
      imask_r <= wdata_i[4:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(istat_r & imask_r);
    end
  end

  // =====================================================
  // read port, data one cycle after the strobe, zero otherwise
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        hbfl_pkg::ADDR_CTRL: rd_nxt = {26'h000_0000, ctrl_r};
        hbfl_pkg::ADDR_GSTAT: rd_nxt = {24'h00_0000, gstat_r};
        hbfl_pkg::ADDR_OCDIAG: rd_nxt = {26'h000_0000, oc_diag_r};
        hbfl_pkg::ADDR_OLDIAG: rd_nxt = {26'h000_0000, ol_diag_r};
        hbfl_pkg::ADDR_IRQ_STAT: rd_nxt = {27'h000_0000, istat_r};
        hbfl_pkg::ADDR_IRQ_MASK: rd_nxt = {27'h000_0000, imask_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_nxt;
    end
  end
endmodule : hbfl_top

// file: sim/hbfl_chk.sv
// checker: port-level assertions for the fault latch
`timescale 1ns/10ps
// =====================================
// assertions
module hbfl_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [5:0] overcurrent_threshold_i,
  input wire logic [5:0] openload_i,
  input wire logic thermal_prewarning_i,
  input wire logic thermal_shutdown_i,
  input wire logic supply_undervoltage_i,
  input wire logic supply_overvoltage_i,
  input wire logic [5:0] switch_on_o,
  input wire logic error_flag_o
);
  logic [7:0] oc_run_r;
  logic glob;
  logic anyf;
  assign glob = thermal_shutdown_i | supply_undervoltage_i |
    supply_overvoltage_i;
  assign anyf = glob | thermal_prewarning_i | (|overcurrent_threshold_i) |
    (|openload_i);
  // saturating run length of a short on switch 0
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) oc_run_r <= 8'h00;
    else if (!overcurrent_threshold_i[0]) oc_run_r <= 8'h00;
    else if (oc_run_r != 8'hff) oc_run_r <= oc_run_r + 8'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence sup_s;
    (supply_undervoltage_i || supply_overvoltage_i) [*4];
  endsequence
  sequence sleep_s;
    !enable_i [*6];
  endsequence
  // 4 samples cover two sync flops plus the output register
  sup_off_a: assert property (sup_s |-> switch_on_o == 6'h00)
    else $error("outputs on during supply fault");
  tsd_off_a: assert property (thermal_shutdown_i [*4] |->
    switch_on_o == 6'h00) else $error("outputs on during shutdown");
  sleep_off_a: assert property (sleep_s |->
    switch_on_o == 6'h00 && !error_flag_o) else $error("sleep not clean");
  rd_idle_a: assert property (!$past(rd_i) |->
    rdata_o == 32'h0000_0000) else $error("read data outside slot");
  flag_fall_a: assert property ($fell(error_flag_o) |->
    $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3) ||
    !$past(enable_i, 3) || !$past(enable_i, 4))
    else $error("error flag fell without clear");
  flag_cause_a: assert property ($rose(error_flag_o) |->
    $past(anyf, 3) || $past(anyf, 4) || $past(anyf, 5))
    else $error("error flag rose without fault");
  oc_early_a: assert property (oc_run_r != 8'h00 &&
    oc_run_r < 8'h5a && !glob |-> switch_on_o[0])
    else $error("switch cut before filter expiry");
  oc_cut_a: assert property (oc_run_r < 8'h6e)
    else $error("shorted switch not cut off");
endmodule : hbfl_chk
bind hbfl_top hbfl_chk u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .enable_i(enable_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .overcurrent_threshold_i(overcurrent_threshold_i),
  .openload_i(openload_i), .thermal_prewarning_i(thermal_prewarning_i),
  .thermal_shutdown_i(thermal_shutdown_i),
  .supply_undervoltage_i(supply_undervoltage_i),
  .supply_overvoltage_i(supply_overvoltage_i),
  .switch_on_o(switch_on_o), .error_flag_o(error_flag_o));

// file: sim/hbfl_load_model.sv
// model: motor load with injectable shorts and open wires
`timescale 1ns/10ps
module hbfl_load_model (
  input wire logic [5:0] switch_on_i,
  input wire logic [5:0] short_i,
  input wire logic [5:0] open_i,
  output logic [5:0] over_thr_o,
  output logic [5:0] open_load_o
);
  // current only flows through a switch that is on
  assign over_thr_o = switch_on_i & short_i;
  assign open_load_o = switch_on_i & open_i;
endmodule : hbfl_load_model

// file: sim/tb_half_bridge_fault_latch.sv
// testbench: register and fault scenarios for the fault latch
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_half_bridge_fault_latch;
  logic clk_i = 0, reset_i = 1, enable_i = 1, wr_i = 0, rd_i = 0;
  logic thermal_prewarning = 0, thermal_shutdown = 0, uv = 0, ov = 0, error_flag_o, irq_o;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000, rdata_o, seed = 32'h3487_4eae;
  logic [5:0] shrt = 6'h00, opn = 6'h00, oc, ol, switch_on_o, v;
  int errors = 0, tests_run = 0;
  initial forever #5 clk_i = ~clk_i;
  hbfl_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .overcurrent_threshold_i(oc), .openload_i(ol),
    .thermal_prewarning_i(thermal_prewarning), .thermal_shutdown_i(thermal_shutdown),
    .supply_undervoltage_i(uv), .supply_overvoltage_i(ov),
    .switch_on_o(switch_on_o), .error_flag_o(error_flag_o), .irq_o(irq_o));
  hbfl_load_model u_load (.switch_on_i(switch_on_o), .short_i(shrt),
    .open_i(opn), .over_thr_o(oc), .open_load_o(ol));
  // =====================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask : rd
  // settle time covers input sync flops and the output register
  task automatic so(input logic [5:0] e);
    cyc(6);
    `CHK(switch_on_o, e)
  endtask : so
  task automatic print_verdict;
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    #500000;
    errors++;
    print_verdict;
  end
  // =====================================
  // scenarios
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    cyc(4);
    rd(hbfl_pkg::ADDR_CTRL, 0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 0);
    wr(hbfl_pkg::ADDR_CTRL, 32'h0000_0009);
    so(6'h09);
    repeat (8) begin
      seed = xs(seed);
      v = seed[5:0];
      wr(hbfl_pkg::ADDR_CTRL, {26'h0, v});
      so(v);
    end
    wr(hbfl_pkg::ADDR_CTRL, 32'h0000_0009);
    @(posedge clk_i) shrt <= 6'h01;
    so(6'h09);
    cyc(110);
    `CHK(switch_on_o, 6'h08)
    @(posedge clk_i) shrt <= 6'h00;
    rd(hbfl_pkg::ADDR_OCDIAG, 1);
    rd(hbfl_pkg::ADDR_GSTAT, 32'h0000_0040);
    rd(hbfl_pkg::ADDR_CTRL, 9);
    so(6'h08);
    `CHK(error_flag_o, 1'b1)
    wr(hbfl_pkg::ADDR_GSTAT, 32'h0000_00ff);
    wr(hbfl_pkg::ADDR_OCDIAG, 1);
    so(6'h09);
    @(posedge clk_i) opn <= 6'h08;
    so(6'h09);
    @(posedge clk_i) opn <= 6'h00;
    rd(hbfl_pkg::ADDR_OLDIAG, 8);
    rd(hbfl_pkg::ADDR_GSTAT, 32'h0000_0040);
    wr(hbfl_pkg::ADDR_GSTAT, 32'h0000_00ff);
    @(posedge clk_i) thermal_prewarning <= 1'b1;
    so(6'h09);
    @(posedge clk_i) thermal_prewarning <= 1'b0;
    rd(hbfl_pkg::ADDR_GSTAT, 2);
    wr(hbfl_pkg::ADDR_GSTAT, 32'h0000_00ff);
    @(posedge clk_i) thermal_shutdown <= 1'b1;
    so(6'h00);
    @(posedge clk_i) thermal_shutdown <= 1'b0;
    so(6'h00);
    rd(hbfl_pkg::ADDR_CTRL, 9);
    wr(hbfl_pkg::ADDR_GSTAT, 32'h0000_00ff);
    so(6'h09);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i) {uv, ov} <= (i == 0) ? 2'b10 : 2'b01;
      so(6'h00);
      @(posedge clk_i) {uv, ov} <= 2'b00;
      so(6'h09);
      rd(hbfl_pkg::ADDR_GSTAT, (i == 0) ? 32'h20 : 32'h10);
      wr(hbfl_pkg::ADDR_GSTAT, 32'h0000_00ff);
    end
    wr(hbfl_pkg::ADDR_IRQ_MASK, 0);
    cyc(3);
    `CHK(irq_o, 1'b0)
    wr(hbfl_pkg::ADDR_IRQ_MASK, 32'h0000_001f);
    cyc(3);
    `CHK(irq_o, 1'b1)
    wr(hbfl_pkg::ADDR_IRQ_STAT, 32'h0000_00ff);
    wr(hbfl_pkg::ADDR_OLDIAG, 32'h0000_00ff);
    cyc(3);
    `CHK(irq_o, 1'b0)
    `CHK(error_flag_o, 1'b0)
    @(posedge clk_i) enable_i <= 1'b0;
    so(6'h00);
    @(posedge clk_i) enable_i <= 1'b1;
    cyc(4);
    rd(hbfl_pkg::ADDR_CTRL, 0);
    print_verdict;
  end
endmodule : tb_half_bridge_fault_latch
